// ===== design/xcvr_mgmt_pkg.sv
// shared constants for the transceiver status and two-wire management block
package xcvr_mgmt_pkg;
  // two-wire device addresses, 7-bit form without the r/w bit
  localparam logic [6:0] ID_PAGE_ADDR   = 7'h50;  // 0xa0 >> 1
  localparam logic [6:0] DIAG_PAGE_ADDR = 7'h51;  // 0xa2 >> 1
  localparam logic [6:0] TEST_PAGE_ADDR = 7'h58;  // 0xb0 >> 1, not answered
  // diagnostics page map
  localparam logic [7:0] STATUS_OFFSET    = 8'h6e;
  localparam int         STAT_SOFT_DIS    = 6;
  localparam int         STAT_TX_DIS      = 7;
  localparam int         STAT_FAULT_BIT   = 2;
  localparam int         STAT_LOSS_BIT    = 1;
  localparam logic [7:0] MEAS_TEMP_OFFSET = 8'h60;  // 96..105, msb first
  localparam int         MEAS_COUNT       = 5;
  localparam logic [7:0] STATUS_RESET     = 8'h00;
  localparam logic [7:0] OFFSET_RESET     = 8'h00;
  localparam logic [3:0] BIT_RESET        = 4'h0;

  typedef enum logic [2:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_WRITE, BUS_WRITE_ACK,
    BUS_READ, BUS_READ_ACK
  } bus_state_t;
endpackage : xcvr_mgmt_pkg

// ===== design/xcvr_mgmt.sv
// fault and loss flags plus two-wire serial memory of the transceiver
`timescale 1ns/1ns
`default_nettype none

module xcvr_mgmt (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        laser_off_pin,
  input  wire logic        laser_fault_det,
  input  wire logic        supply_low_det,
  input  wire logic        rx_power_weak,
  input  wire logic [15:0] meas_value [5],
  input  wire logic [7:0]  id_rom_data,
  output logic      [7:0]  id_rom_addr,
  output logic             laser_enable,
  output logic             tx_fault_out,
  output logic             tx_fault_oe,
  output logic             receive_signal_lost,
  output logic             module_present_pin,
  input  wire logic        two_wire_clock_pin,
  input  wire logic        two_wire_data_in,
  output logic             two_wire_data_out,
  output logic             two_wire_data_oe
);
  typedef struct packed {
    logic [1:0]              off_sync;
    logic [1:0]              scl_sync;
    logic [1:0]              sda_sync;
    logic                    scl_prev;
    logic                    sda_prev;
    logic                    off_prev;
    logic                    fault_latch;
    logic                    fault_out;
    logic                    loss_out;
    logic [7:0]              status;
    xcvr_mgmt_pkg::bus_state_t st;
    logic [3:0]              bitcnt;
    logic [7:0]              shift;
    logic                    diag_sel;
    logic                    rd;
    logic                    got_offset;
    logic [7:0]              offset;
    logic                    sda_low;
  } state_t;

  state_t s_q, s_d;

  // byte of the selected page at an offset; reads never change state
  function automatic logic [7:0] page_byte(input logic diag,
                                           input logic [7:0] off,
                                           input logic [7:0] stat,
                                           input logic [7:0] idb,
                                           input logic [15:0] m [5]);
    logic [7:0] rel;
    rel = off - xcvr_mgmt_pkg::MEAS_TEMP_OFFSET;
    page_byte = 8'h00;
    if (!diag) begin
      page_byte = idb;
    end else if (off == xcvr_mgmt_pkg::STATUS_OFFSET) begin
      page_byte = stat;
    end else if (off >= xcvr_mgmt_pkg::MEAS_TEMP_OFFSET &&
                 rel < 8'(2 * xcvr_mgmt_pkg::MEAS_COUNT)) begin
      page_byte = rel[0] ? m[rel[3:1]][7:0] : m[rel[3:1]][15:8];
    end
  endfunction : page_byte

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] rd_byte;

  assign scl_rise = s_q.scl_sync[1] && !s_q.scl_prev;
  assign scl_fall = !s_q.scl_sync[1] && s_q.scl_prev;
  assign start_c  = s_q.scl_sync[1] && s_q.sda_prev && !s_q.sda_sync[1];
  assign stop_c   = s_q.scl_sync[1] && !s_q.sda_prev && s_q.sda_sync[1];
  assign id_rom_addr = s_q.offset;
  // live measurements and status come straight from the map
  assign rd_byte = page_byte(s_q.diag_sel, s_q.offset, s_q.status,
                             id_rom_data, meas_value);

  // next state of flags and serial slave
  always_comb begin
    s_d = s_q;
    s_d.off_sync = {s_q.off_sync[0], laser_off_pin};
    s_d.scl_sync = {s_q.scl_sync[0], two_wire_clock_pin};
    s_d.sda_sync = {s_q.sda_sync[0], two_wire_data_in};
    s_d.scl_prev = s_q.scl_sync[1];
    s_d.sda_prev = s_q.sda_sync[1];
    s_d.off_prev = s_q.off_sync[1];
    // any edge of laser-off clears the latch; a new fault wins
    if (s_q.off_sync[1] != s_q.off_prev) begin
      s_d.fault_latch = 1'b0;
    end
    // laser fault latches; only hardware sources feed it
    if (laser_fault_det) begin
      s_d.fault_latch = 1'b1;
    end
    // supply fault passes straight through, unlatched
    s_d.fault_out = s_d.fault_latch || supply_low_det;
    // loss of signal follows detector level
    s_d.loss_out = rx_power_weak;
    s_d.status[xcvr_mgmt_pkg::STAT_TX_DIS]    = s_q.off_sync[1];
    s_d.status[xcvr_mgmt_pkg::STAT_FAULT_BIT] = s_d.fault_out;
    s_d.status[xcvr_mgmt_pkg::STAT_LOSS_BIT]  = s_d.loss_out;

    if (stop_c) begin
      s_d.st = xcvr_mgmt_pkg::BUS_IDLE;
      s_d.sda_low = 1'b0;
    end else if (start_c) begin
      s_d.st = xcvr_mgmt_pkg::BUS_ADDR;
      s_d.bitcnt = xcvr_mgmt_pkg::BIT_RESET;
      s_d.sda_low = 1'b0;
    end else begin
      case (s_q.st)
        xcvr_mgmt_pkg::BUS_IDLE: s_d.sda_low = 1'b0;
        xcvr_mgmt_pkg::BUS_ADDR, xcvr_mgmt_pkg::BUS_WRITE: begin
          if (scl_rise) begin
            s_d.shift = {s_q.shift[6:0], s_q.sda_sync[1]};
            s_d.bitcnt = s_q.bitcnt + 4'h1;
          end
          if (scl_fall && s_q.bitcnt == 4'h8) begin
            s_d.bitcnt = xcvr_mgmt_pkg::BIT_RESET;
            if (s_q.st == xcvr_mgmt_pkg::BUS_ADDR) begin
              // only the two pages are acknowledged
              if (s_q.shift[7:1] == xcvr_mgmt_pkg::ID_PAGE_ADDR ||
                  s_q.shift[7:1] == xcvr_mgmt_pkg::DIAG_PAGE_ADDR) begin
                s_d.diag_sel = s_q.shift[1];
                s_d.rd = s_q.shift[0];
                s_d.got_offset = 1'b0;
                s_d.sda_low = 1'b1;
                s_d.st = xcvr_mgmt_pkg::BUS_ADDR_ACK;
              end else begin
                s_d.st = xcvr_mgmt_pkg::BUS_IDLE;
              end
            end else begin
              // first write byte sets the offset
              if (!s_q.got_offset) begin
                s_d.offset = s_q.shift;
                s_d.got_offset = 1'b1;
              end else begin
                // status byte takes the software disable bit
                if (s_q.diag_sel &&
                    s_q.offset == xcvr_mgmt_pkg::STATUS_OFFSET) begin
                  s_d.status[xcvr_mgmt_pkg::STAT_SOFT_DIS] =
                    s_q.shift[xcvr_mgmt_pkg::STAT_SOFT_DIS];
                end
                s_d.offset = s_q.offset + 8'h01;
              end
              s_d.sda_low = 1'b1;
              s_d.st = xcvr_mgmt_pkg::BUS_WRITE_ACK;
            end
          end
        end
        xcvr_mgmt_pkg::BUS_ADDR_ACK, xcvr_mgmt_pkg::BUS_WRITE_ACK: begin
          if (scl_fall) begin
            if (s_q.st == xcvr_mgmt_pkg::BUS_ADDR_ACK && s_q.rd) begin
              s_d.shift = rd_byte;
              s_d.sda_low = !rd_byte[7];
              s_d.bitcnt = 4'h1;
              s_d.st = xcvr_mgmt_pkg::BUS_READ;
            end else begin
              s_d.sda_low = 1'b0;
              s_d.st = xcvr_mgmt_pkg::BUS_WRITE;
            end
          end
        end
        xcvr_mgmt_pkg::BUS_READ: begin
          if (scl_fall) begin
            if (s_q.bitcnt == 4'h8) begin
              // offset advances after each byte returned
              s_d.offset = s_q.offset + 8'h01;
              s_d.sda_low = 1'b0;
              s_d.st = xcvr_mgmt_pkg::BUS_READ_ACK;
            end else begin
              s_d.shift = {s_q.shift[6:0], 1'b0};
              s_d.sda_low = !s_q.shift[6];
              s_d.bitcnt = s_q.bitcnt + 4'h1;
            end
          end
        end
        xcvr_mgmt_pkg::BUS_READ_ACK: begin
          // master ack continues the burst, nack ends it
          if (scl_rise && s_q.sda_sync[1]) begin
            s_d.st = xcvr_mgmt_pkg::BUS_IDLE;
          end else if (scl_fall) begin
            s_d.shift = rd_byte;
            s_d.sda_low = !rd_byte[7];
            s_d.bitcnt = 4'h1;
            s_d.st = xcvr_mgmt_pkg::BUS_READ;
          end
        end
        default: s_d.st = xcvr_mgmt_pkg::BUS_IDLE;
      endcase
    end
  end

  // one register bank for the whole module
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.status <= xcvr_mgmt_pkg::STATUS_RESET;
      s_q.offset <= xcvr_mgmt_pkg::OFFSET_RESET;
      s_q.scl_sync <= 2'h3;
      s_q.sda_sync <= 2'h3;
      s_q.scl_prev <= 1'b1;
      s_q.sda_prev <= 1'b1;
      s_q.off_sync <= 2'h3;
      s_q.off_prev <= 1'b1;
      s_q.st <= xcvr_mgmt_pkg::BUS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // laser runs only with no fault and no disable
  assign laser_enable = !s_q.fault_out && !s_q.off_sync[1] &&
                        !s_q.status[xcvr_mgmt_pkg::STAT_SOFT_DIS];
  // pin pulled low in normal operation, released on fault
  assign tx_fault_out = 1'b0;
  assign tx_fault_oe  = !s_q.fault_out;
  assign receive_signal_lost = s_q.loss_out;
  assign module_present_pin = 1'b0;
  assign two_wire_data_out  = 1'b0;
  assign two_wire_data_oe   = s_q.sda_low;

  // latch holds while laser-off is steady
  fault_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_q.fault_latch && s_q.off_sync[1] == s_q.off_prev
    |=> s_q.fault_latch) else $error("fault latch dropped");
  // fault reaches the pin and stops the laser
  fault_pin_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    laser_fault_det |-> ##1 !tx_fault_oe ##0 !laser_enable)
    else $error("fault not shown on pin");
  // supply fault never outlives the supply dip
  supply_follow_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    supply_low_det && !s_q.fault_latch ##1 !supply_low_det && !s_d.fault_latch
    |=> tx_fault_oe) else $error("supply fault latched");
  // status bits agree with the pins the host sees
  status_mirror_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_q.status[xcvr_mgmt_pkg::STAT_FAULT_BIT] == !tx_fault_oe &&
    s_q.status[xcvr_mgmt_pkg::STAT_LOSS_BIT] == receive_signal_lost)
    else $error("status mirror mismatch");
  // loss output one edge behind the detector
  loss_follow_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rx_power_weak |=> receive_signal_lost) else $error("loss missed");
  // software disable keeps the laser dark
  soft_disable_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_q.status[xcvr_mgmt_pkg::STAT_SOFT_DIS] |-> !laser_enable)
    else $error("soft disable ignored");
  // reserved page address is never acknowledged
  test_page_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_q.st == xcvr_mgmt_pkg::BUS_ADDR && scl_fall && s_q.bitcnt == 4'h8 &&
    s_q.shift[7:1] == xcvr_mgmt_pkg::TEST_PAGE_ADDR && !start_c && !stop_c
    |=> !two_wire_data_oe) else $error("reserved page acked");
  // offset steps once per byte returned
  read_step_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_q.st == xcvr_mgmt_pkg::BUS_READ && scl_fall && s_q.bitcnt == 4'h8 &&
    !start_c && !stop_c |=> s_q.offset == $past(s_q.offset) + 8'h01)
    else $error("offset did not step");
endmodule : xcvr_mgmt
`default_nettype wire

// ===== dv/host_master.sv
// two-wire bus master model standing in for the host board controller
`timescale 1ns/1ns
`default_nettype none
module host_master (
  output logic      scl,
  output logic      sda_oe,
  input  wire logic sda
);
  // idle bus: clock stands high, data released to its pull-up
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic bit_out(input logic b);
    #31 sda_oe = ~b;  // data moves only while the clock is low
    #32 scl = 1'b1;
    #62 scl = 1'b0;
  endtask : bit_out
  // sample in the middle of the high phase, after the device settled
  task automatic bit_in(output logic b);
    #31 sda_oe = 1'b0;
    #32 scl = 1'b1;
    #31 b = sda;
    #31 scl = 1'b0;
  endtask : bit_in
  // start, also serves as repeated start with the clock low
  task automatic start();
    #31 sda_oe = 1'b0;
    #31 scl = 1'b1;
    #31 sda_oe = 1'b1;
    #31 scl = 1'b0;
  endtask : start
  task automatic stop();
    #31 sda_oe = 1'b1;
    #32 scl = 1'b1;
    #31 sda_oe = 1'b0;
    #31;
  endtask : stop
  // bytes go msb first, ninth bit is the acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_out(b[i]);
    bit_in(a);
    ack = ~a;
  endtask : wbyte
  // a nack on the last byte tells the device to let go of the line
  task automatic rbyte(output logic [7:0] b, input logic last);
    for (int i = 7; i >= 0; i--)
      bit_in(b[i]);
    bit_out(last);
  endtask : rbyte
endmodule : host_master
`default_nettype wire

// ===== dv/xcvr_mgmt_tb.sv
// self-checking bench for the transceiver status and two-wire block
`timescale 1ns/1ns
`default_nettype none
module xcvr_mgmt_tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        laser_off_pin = 1'b0;
  logic        laser_fault_det = 1'b0;
  logic        supply_low_det = 1'b0;
  logic        rx_power_weak = 1'b0;
  logic [15:0] meas [5];
  logic [7:0]  id_rom_addr;
  logic        laser_enable, tx_fault_out, tx_fault_oe, loss;
  logic        present, sda_out, dut_oe, scl, host_oe, ack;
  logic [7:0]  rb [10];
  int          error_cnt = 0;
  int          n_tests = 0;
  wire logic   sda;
  // wired-and data line with the host's pull-up
  assign sda = ~(dut_oe | host_oe);
  always #4 ref_clk = ~ref_clk;
  xcvr_mgmt dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .laser_off_pin(laser_off_pin), .laser_fault_det(laser_fault_det),
    .supply_low_det(supply_low_det), .rx_power_weak(rx_power_weak),
    .meas_value(meas), .id_rom_data(~id_rom_addr),
    .id_rom_addr(id_rom_addr), .laser_enable(laser_enable),
    .tx_fault_out(tx_fault_out), .tx_fault_oe(tx_fault_oe),
    .receive_signal_lost(loss), .module_present_pin(present),
    .two_wire_clock_pin(scl), .two_wire_data_in(sda),
    .two_wire_data_out(sda_out), .two_wire_data_oe(dut_oe));
  host_master host (.scl(scl), .sda_oe(host_oe), .sda(sda));
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic tick(int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick
  // random read: set offset, restart, then n bytes in sequence
  task automatic rd(logic [6:0] dev, logic [7:0] off, int n);
    host.start();
    host.wbyte({dev, 1'b0}, ack);
    chk("address ack", ack, 8'h01);
    host.wbyte(off, ack);
    host.start();
    host.wbyte({dev, 1'b1}, ack);
    for (int i = 0; i < n; i++)
      host.rbyte(rb[i], i == n - 1);
    host.stop();
  endtask : rd
  task automatic wr(logic [7:0] d);
    host.start();
    host.wbyte({xcvr_mgmt_pkg::DIAG_PAGE_ADDR, 1'b0}, ack);
    host.wbyte(xcvr_mgmt_pkg::STATUS_OFFSET, ack);
    host.wbyte(d, ack);
    host.stop();
    chk("write ack", ack, 8'h01);
    tick(4);
  endtask : wr
  task automatic t_reset();
    chk("present pin", present, 8'h00);
    chk("fault pin pulled low", tx_fault_oe, 8'h01);
    chk("fault drive level", tx_fault_out, 8'h00);
    chk("data drive level", sda_out, 8'h00);
    chk("loss idle", loss, 8'h00);
    chk("laser allowed", laser_enable, 8'h01);
  endtask : t_reset
  // latched laser fault survives its cause and a status read
  task automatic t_laser_fault();
    laser_fault_det = 1'b1;
    tick(3);
    laser_fault_det = 1'b0;
    tick(2);
    chk("fault raised", tx_fault_oe, 8'h00);
    chk("laser stopped", laser_enable, 8'h00);
    tick(20);
    chk("fault latched", tx_fault_oe, 8'h00);
    rd(xcvr_mgmt_pkg::DIAG_PAGE_ADDR, xcvr_mgmt_pkg::STATUS_OFFSET, 1);
    chk("status fault", rb[0], 8'h04);
    tick(1);
    chk("fault kept after read", tx_fault_oe, 8'h00);
    laser_off_pin = 1'b1;
    tick(6);
    laser_off_pin = 1'b0;
    tick(6);
    chk("fault cleared", tx_fault_oe, 8'h01);
    chk("laser restarted", laser_enable, 8'h01);
  endtask : t_laser_fault
  task automatic t_supply();
    supply_low_det = 1'b1;
    tick(2);
    chk("supply fault", tx_fault_oe, 8'h00);
    chk("laser off on supply", laser_enable, 8'h00);
    supply_low_det = 1'b0;
    tick(2);
    chk("supply fault gone", tx_fault_oe, 8'h01);
  endtask : t_supply
  // a power cycle in mid-run must drop a latched fault
  task automatic t_power_cycle();
    laser_fault_det = 1'b1;
    tick(1);
    laser_fault_det = 1'b0;
    tick(3);
    chk("fault before cycle", tx_fault_oe, 8'h00);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(6);
    chk("fault cleared by cycle", tx_fault_oe, 8'h01);
  endtask : t_power_cycle
  task automatic t_loss();
    rx_power_weak = 1'b1;
    tick(2);
    chk("loss raised", loss, 8'h01);
    rd(xcvr_mgmt_pkg::DIAG_PAGE_ADDR, xcvr_mgmt_pkg::STATUS_OFFSET, 1);
    chk("status loss", rb[0], 8'h02);
    tick(1);
    rx_power_weak = 1'b0;
    tick(2);
    chk("loss dropped", loss, 8'h00);
    rd(xcvr_mgmt_pkg::DIAG_PAGE_ADDR, xcvr_mgmt_pkg::STATUS_OFFSET, 1);
    chk("status live", rb[0], 8'h00);
  endtask : t_loss
  // ends at the top of the id page to catch offset slips
  task automatic t_id();
    rd(xcvr_mgmt_pkg::ID_PAGE_ADDR, 8'hfd, 3);
    for (int i = 0; i < 3; i++)
      chk("id byte", rb[i], ~(8'hfd + 8'(i)));
  endtask : t_id
  task automatic t_diag();
    rd(xcvr_mgmt_pkg::DIAG_PAGE_ADDR, xcvr_mgmt_pkg::MEAS_TEMP_OFFSET, 10);
    for (int k = 0; k < 5; k++) begin
      chk("meas high", rb[2*k], meas[k][15:8]);
      chk("meas low", rb[2*k+1], meas[k][7:0]);
    end
  endtask : t_diag
  task automatic t_reserved();
    host.start();
    host.wbyte({xcvr_mgmt_pkg::TEST_PAGE_ADDR, 1'b0}, ack);
    host.stop();
    chk("reserved page nack", ack, 8'h00);
  endtask : t_reserved
  // software disable, then the hardware laser-off level
  task automatic t_soft();
    wr(8'h40);
    chk("soft disable", laser_enable, 8'h00);
    rd(xcvr_mgmt_pkg::DIAG_PAGE_ADDR, xcvr_mgmt_pkg::STATUS_OFFSET, 1);
    chk("status soft", rb[0], 8'h40);
    wr(8'h00);
    chk("soft enable", laser_enable, 8'h01);
    laser_off_pin = 1'b1;
    tick(6);
    chk("pin disable", laser_enable, 8'h00);
    rd(xcvr_mgmt_pkg::DIAG_PAGE_ADDR, xcvr_mgmt_pkg::STATUS_OFFSET, 1);
    chk("status pin", rb[0], 8'h80);
  endtask : t_soft
  // main sequence
  initial begin
    foreach (meas[k])
      meas[k] = 16'h1a2b + 16'(k) * 16'h1111;
    tick(20);
    rst_n = 1'b1;
    tick(6);
    t_reset();
    t_laser_fault();
    t_supply();
    t_power_cycle();
    t_loss();
    t_id();
    t_diag();
    t_reserved();
    t_soft();
    end_of_test();
  end
  // watchdog: the sequence needs about 56 us
  initial begin
    #300000;
    error_cnt++;
    end_of_test();
  end
endmodule : xcvr_mgmt_tb
`default_nettype wire
